// ---- inc/dlo_defines.vh ----
/*
 constants for the read-strobe delay offset and update control block:
 register offsets, field positions, reset values and timing counts.
 assumes it is included by bare name from the design files.
*/
`ifndef DLO_DEFINES_VH
`define DLO_DEFINES_VH

// register byte addresses on the apb slave
`define DLO_ADDR_CONFIG     12'h000
`define DLO_ADDR_READBACK   12'h004
`define DLO_ADDR_RELOAD     12'h008
`define DLO_ADDR_UPDSTAT    12'h00c

// field layout of one lane inside config and readback
`define DLO_LANE_STRIDE     8
`define DLO_DIR_BIT         7
`define DLO_CODE_MSB        6

// reset values and lane clamp limits
`define DLO_CONFIG_RESET    32'h0000_0000
`define DLO_RELOAD_RESET    8'h36
`define DLO_CODE_MAX        7'h7f
`define DLO_CODE_MIN        7'h00

// last count of the 32-clock master delay line refresh and counter enable period
`define DLO_DIV_PERIOD      5'h1f

// longest bus takeover in clocks
`define DLO_MAX_TAKEOVER    3

`endif

// ---- verilog/dlo_lane_adder.v ----
/*
 one lane saturating adder: applies a signed offset to the raw delay code.
 assumes the raw code and offset are stable inputs on the same clock.
*/
`timescale 1ns/1ns
`include "dlo_defines.vh"

module dlo_lane_adder (
   input  wire [6:0] raw_code,     // raw master delay code
   input  wire [6:0] offset_mag,   // offset magnitude
   input  wire       offset_sub,   // 1 subtracts, 0 adds
   output reg  [6:0] lane_code,    // clamped result
   output reg        lane_sat      // result was clamped
);

   reg [7:0] sum;

   // eight-bit sum keeps the carry or borrow that signals saturation
   always @* begin
      sum = 8'h00;
      if (offset_sub) begin
         sum = {1'b0, raw_code} - {1'b0, offset_mag};
      end else begin
         sum = {1'b0, raw_code} + {1'b0, offset_mag};
      end
      lane_sat = sum[7];
      if (sum[7] && offset_sub) begin
         lane_code = `DLO_CODE_MIN;
      end else if (sum[7]) begin
         lane_code = `DLO_CODE_MAX;
      end else begin
         lane_code = sum[6:0];
      end
   end

endmodule // dlo_lane_adder

// ---- verilog/dlo_offset_ctrl.v ----
/*
 read-strobe delay offset and periodic slave update control.
 holds the offset config and readback registers on apb, four lane adders,
 the self-reloading update counter and the dummy bus arbiter.
 assumes the master delay cell gives a raw code and a divide-by-32 enable
 on CLK, and the memory controller core acknowledges bus release.
*/
`timescale 1ns/1ns
`include "dlo_defines.vh"

// Summary of operation
// - raw seven-bit master code arrives, refreshed every 32 clocks
// - raw code goes to four slave lanes, each with its own adder
// - lane results clamp to 7f above and 00 below
// - direction bits 31,23,15,7: zero adds, one subtracts
// - offset magnitudes at 30:24, 22:16, 14:8, 6:0
// - reset leaves all offsets zero so raw code passes unchanged
// - config and readback registers are 32 bits wide
// - readback shows adjusted lane codes at the offset field positions
// - readback bits 31,23,15,7 flag lane saturation
// - self-reloading counter with eight-bit reload requests updates
// - counter advances only on the divide-by-32 enable
// - reload value resets to 54 decimal
// - updates have no disable control
// - dummy arbiter grants the bus to the memory controller by default
// - update request raises backoff; controller releases after its transaction
// - after release, pulse the active-low slave load
// - bus taken from the controller for at most three clocks
// - only read strobes are delayed; write strobes pass untouched
module dlo_offset_ctrl (
   input  wire        CLK,                  // memory clock, 125 MHz
   input  wire        RESET_N,              // synchronous reset, active low
   input  wire        PSEL,                 // apb select
   input  wire        PENABLE,              // apb access phase
   input  wire        PWRITE,               // apb direction
   input  wire [11:0] PADDR,                // apb byte address
   input  wire [31:0] PWDATA,               // apb write data
   output reg  [31:0] PRDATA,               // apb read data
   output reg         PREADY,               // apb ready
   output reg         PSLVERR,              // apb error, unmapped address
   input  wire [6:0]  RAW_CODE,             // master delay code
   input  wire        DIV32_EN,             // divide-by-32 enable from master
   input  wire [7:0]  SYS_RELOAD,           // reload value from system controller
   input  wire        SYS_RELOAD_LOAD,      // one-clock strobe to take SYS_RELOAD
   input  wire        BUS_RELEASED,         // controller has released the bus
   output reg  [27:0] LANE_CODES,           // adjusted codes, lane 3 high
   output reg         SLAVE_DELAY_LOAD_N,   // active-low slave load pulse
   output reg         BUS_BACKOFF,          // asks the controller to release
   output reg         BUS_GRANT,            // dummy arbiter grant to controller
   output reg         UPDATE_REQ            // update request pending
);

   // one-hot update sequencer states
   localparam [3:0] ST_IDLE  = 4'b0001;
   localparam [3:0] ST_WAIT  = 4'b0010;
   localparam [3:0] ST_LOAD  = 4'b0100;
   localparam [3:0] ST_RET   = 4'b1000;

   reg  [31:0] config_reg;
   reg  [31:0] config_next;
   reg  [31:0] readback_reg;
   reg  [7:0]  reload_reg;
   reg  [7:0]  reload_next;
   reg  [7:0]  count_reg;
   reg  [7:0]  count_next;
   reg  [3:0]  state_reg;
   reg  [3:0]  state_next;
   reg  [7:0]  upd_total_reg;
   reg  [31:0] rdata_next;
   reg         err_next;
   reg         ready_next;
   wire [27:0] lane_code_w;
   wire [3:0]  lane_sat_w;
   wire        apb_setup;
   wire        apb_wr;
   wire        terminal;
   // address selects and next values of the registered outputs
   wire        sel_config;
   wire        sel_readback;
   wire        sel_reload;
   wire        sel_updstat;
   reg  [31:0] readback_next;
   reg  [27:0] lane_codes_next;
   reg  [7:0]  upd_total_next;
   reg         load_n_next;
   reg         backoff_next;
   reg         grant_next;
   reg         req_next;

   // compares an apb address with one register word
   function addr_is;
      input [11:0] a;
      input [11:0] reg_addr;
      begin
         addr_is = (a == reg_addr);
      end
   endfunction

   // true when the one-hot state vector holds any of the given state bits
   function in_state;
      input [3:0] s;
      input [3:0] states;
      begin
         in_state = |(s & states);
      end
   endfunction

   // packs one lane's flag and code into its byte of the readback word
   function [7:0] pack_lane;
      input       sat;
      input [6:0] code;
      begin
         pack_lane = {sat, code};
      end
   endfunction

   // tells whether an address is one of the mapped words
   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `DLO_ADDR_CONFIG) || (a == `DLO_ADDR_READBACK) ||
                  (a == `DLO_ADDR_RELOAD) || (a == `DLO_ADDR_UPDSTAT);
      end
   endfunction

   // one adder per byte lane; raw code shared by all four
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : lane
         dlo_lane_adder dlo_lane_adder_inst (
            .raw_code   (RAW_CODE),
            .offset_mag (config_reg[g*`DLO_LANE_STRIDE +: 7]),
            .offset_sub (config_reg[g*`DLO_LANE_STRIDE + `DLO_DIR_BIT]),
            .lane_code  (lane_code_w[g*7 +: 7]),
            .lane_sat   (lane_sat_w[g])
         );
      end
   endgenerate

   // zero-wait-state apb: request taken in setup, answered one clock later
   assign apb_setup = PSEL && !PENABLE;
   assign apb_wr    = PSEL && PENABLE && PREADY && PWRITE;

   // one select per mapped word, shared by the write and read decode
   assign sel_config   = addr_is(PADDR, `DLO_ADDR_CONFIG);
   assign sel_readback = addr_is(PADDR, `DLO_ADDR_READBACK);
   assign sel_reload   = addr_is(PADDR, `DLO_ADDR_RELOAD);
   assign sel_updstat  = addr_is(PADDR, `DLO_ADDR_UPDSTAT);

   // counter expiry; the enable from the master cell gates every count
   assign terminal  = DIV32_EN && (count_reg == 8'h00);

   // register write decode; an apb write in the same clock as the strobe wins,
   // since software should see the value it wrote last
   always @* begin
      config_next = config_reg;
      reload_next = reload_reg;
      // the system controller strobe reloads the update interval
      if (SYS_RELOAD_LOAD) begin
         reload_next = SYS_RELOAD;
      end
      if (apb_wr && sel_config) begin
         config_next = PWDATA;
      end
      if (apb_wr && sel_reload) begin
         // only the low byte is held; the upper bits are dropped on purpose
         reload_next = PWDATA[7:0];
      end
   end

   // register read decode and answer; readback and status ignore writes
   always @* begin
      rdata_next = 32'h0000_0000;
      err_next   = 1'b0;
      ready_next = apb_setup;
      // reads are decoded in the setup cycle and held in PRDATA for the access
      if (apb_setup && !PWRITE) begin
         if (sel_config) begin
            rdata_next = config_reg;
         end else if (sel_readback) begin
            rdata_next = readback_reg;
         end else if (sel_reload) begin
            rdata_next = {24'h00_0000, reload_reg};
         end else if (sel_updstat) begin
            rdata_next = {20'h0_0000, state_reg, upd_total_reg};
         end else begin
            rdata_next = 32'h0000_0000;
         end
      end
      // an unmapped word answers with an error in the same access cycle
      if (apb_setup && !mapped(PADDR)) begin
         err_next = 1'b1;
      end
   end

   // update counter; no enable bit exists, so it never stops
   always @* begin
      count_next = count_reg;
      if (terminal) begin
         // reload at expiry keeps the period fixed at reload plus one enables
         count_next = reload_reg;
      end else if (DIV32_EN) begin
         // one count per enable gives 32 clocks per step
         count_next = count_reg - 8'h01;
      end
   end

   // update sequencer: the counter expiry raises backoff and the request,
   // the controller's release starts a one-clock load pulse, and one more
   // clock hands the bus back; the grant is away for two clocks in all
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            // counter expiry is the only way in; there is no enable to gate it
            if (terminal) begin
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // a controller that never lets go stalls the update; no timeout
            if (BUS_RELEASED) begin
               state_next = ST_LOAD;
            end
         end
         ST_LOAD: begin
            // one clock of load is enough for the slave cells to take the code
            state_next = ST_RET;
         end
         ST_RET: begin
            // the release has been used; the bus goes back next clock
            state_next = ST_IDLE;
         end
         default: begin
            // an illegal code falls back to idle with the bus granted
            state_next = ST_IDLE;
         end
      endcase
   end

   // next values of the registered outputs, all but the readback word decoded from the next state
   // so that every pin changes in the same clock as the sequencer
   always @* begin
      lane_codes_next = LANE_CODES;
      upd_total_next  = upd_total_reg;
      // codes reach the slaves only at the load pulse, when no strobe is in flight
      if (in_state(state_next, ST_LOAD)) begin
         lane_codes_next = lane_code_w;
      end
      // one more finished update each time the bus is handed back
      if (in_state(state_next, ST_RET)) begin
         upd_total_next = upd_total_reg + 8'h01;
      end
      load_n_next  = !in_state(state_next, ST_LOAD);
      // backoff and request are one level; the controller sees the same pulse
      backoff_next = in_state(state_next, ST_WAIT | ST_LOAD);
      // grant drops while the load runs and for the one clock after it, so takeover stays within bounds
      grant_next   = in_state(state_next, ST_IDLE | ST_WAIT);
      req_next     = in_state(state_next, ST_WAIT | ST_LOAD);
      // readback tracks adjusted codes and saturation flags live
      readback_next = {pack_lane(lane_sat_w[3], lane_code_w[27:21]),
                       pack_lane(lane_sat_w[2], lane_code_w[20:14]),
                       pack_lane(lane_sat_w[1], lane_code_w[13:7]),
                       pack_lane(lane_sat_w[0], lane_code_w[6:0])};
   end

   // every register of the block sits below; splitting them by purpose keeps
   // each reset branch short and holds every output on its own flip-flop

   // apb side registers and the answer to the master
   always @(posedge CLK) begin
      if (!RESET_N) begin
         config_reg <= `DLO_CONFIG_RESET;
         reload_reg <= `DLO_RELOAD_RESET;
         PRDATA     <= 32'h0000_0000;
         PREADY     <= 1'b0;
         PSLVERR    <= 1'b0;
      end else begin
         config_reg <= config_next;
         reload_reg <= reload_next;
         PRDATA     <= rdata_next;
         PREADY     <= ready_next;
         PSLVERR    <= err_next;
      end
   end

   // update counter and sequencer state; reset loads the full interval
   always @(posedge CLK) begin
      if (!RESET_N) begin
         count_reg <= `DLO_RELOAD_RESET;
         state_reg <= ST_IDLE;
      end else begin
         count_reg <= count_next;
         state_reg <= state_next;
      end
   end

   // finished update count, shown in the status word
   always @(posedge CLK) begin
      if (!RESET_N) begin
         upd_total_reg <= 8'h00;
      end else begin
         upd_total_reg <= upd_total_next;
      end
   end

   // readback word; it shows zero for one clock after reset, then live codes
   always @(posedge CLK) begin
      if (!RESET_N) begin
         readback_reg <= 32'h0000_0000;
      end else begin
         readback_reg <= readback_next;
      end
   end

   // codes held by the slave lines; they move only at the load pulse
   always @(posedge CLK) begin
      if (!RESET_N) begin
         LANE_CODES <= 28'h000_0000;
      end else begin
         LANE_CODES <= lane_codes_next;
      end
   end

   // arbiter and load outputs, each straight from its own flip-flop
   always @(posedge CLK) begin
      if (!RESET_N) begin
         SLAVE_DELAY_LOAD_N <= 1'b1;
         BUS_BACKOFF        <= 1'b0;
         // grant is high out of reset: the controller owns the bus by default
         BUS_GRANT          <= 1'b1;
         UPDATE_REQ         <= 1'b0;
      end else begin
         SLAVE_DELAY_LOAD_N <= load_n_next;
         BUS_BACKOFF        <= backoff_next;
         BUS_GRANT          <= grant_next;
         UPDATE_REQ         <= req_next;
      end
   end

   // write strobes are not routed through this block at all

endmodule // dlo_offset_ctrl

// ---- verif/dlo_offset_ctrl_assertions.sv ----
/* checker for the update handshake and apb answer timing.
 assumes it is bound to dlo_offset_ctrl and sees its ports only. */
`timescale 1ns/1ns
module dlo_offset_ctrl_assertions (
   input wire        CLK,                 // clock
   input wire        RESET_N,             // sync reset, active low
   input wire        PSEL,                // apb select
   input wire        PENABLE,             // apb access
   input wire        PREADY,              // apb ready
   input wire [27:0] LANE_CODES,          // slave lane codes
   input wire        SLAVE_DELAY_LOAD_N,  // slave load, active low
   input wire        BUS_RELEASED,        // bus let go
   input wire        BUS_BACKOFF,         // backoff request
   input wire        BUS_GRANT,           // grant to controller
   input wire        UPDATE_REQ           // update pending
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // load must wait for the release, then the bus returns quickly
   a_load_on_release: assert property (BUS_BACKOFF && BUS_RELEASED && SLAVE_DELAY_LOAD_N |=> !SLAVE_DELAY_LOAD_N)
      else $error("no load after release");
   a_load_one_clk: assert property (!SLAVE_DELAY_LOAD_N |=> SLAVE_DELAY_LOAD_N)
      else $error("load pulse too long");
   a_load_in_backoff: assert property (!SLAVE_DELAY_LOAD_N |-> BUS_BACKOFF && !BUS_GRANT)
      else $error("load outside takeover");
   a_return_after_load: assert property (!SLAVE_DELAY_LOAD_N |=> !BUS_BACKOFF && !UPDATE_REQ ##1 BUS_GRANT)
      else $error("bus not returned");
   a_takeover_max: assert property ($fell(BUS_GRANT) |-> !BUS_GRANT [*2] ##1 BUS_GRANT)
      else $error("takeover length wrong");
   a_req_is_backoff: assert property (UPDATE_REQ == BUS_BACKOFF)
      else $error("request and backoff differ");
   a_grant_default: assert property (!BUS_BACKOFF && $past(SLAVE_DELAY_LOAD_N) |-> BUS_GRANT)
      else $error("grant missing");
   a_backoff_holds: assert property (BUS_BACKOFF && SLAVE_DELAY_LOAD_N |=> BUS_BACKOFF)
      else $error("backoff dropped early");
   a_codes_at_load: assert property (!$stable(LANE_CODES) |-> !SLAVE_DELAY_LOAD_N)
      else $error("lane codes moved outside load");
   a_apb_ready: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready in access");
endmodule // dlo_offset_ctrl_assertions

bind dlo_offset_ctrl dlo_offset_ctrl_assertions chk_inst (.CLK(CLK), .RESET_N(RESET_N),
   .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .LANE_CODES(LANE_CODES),
   .SLAVE_DELAY_LOAD_N(SLAVE_DELAY_LOAD_N), .BUS_RELEASED(BUS_RELEASED),
   .BUS_BACKOFF(BUS_BACKOFF), .BUS_GRANT(BUS_GRANT), .UPDATE_REQ(UPDATE_REQ));

// ---- verif/dlo_mc_model.sv ----
/* model of the master delay cell enable and of the memory controller core.
 assumes one clock; rel_delay sets how long the current transfer runs on. */
`timescale 1ns/1ns
module dlo_mc_model (
   input  wire       clk,           // clock
   input  wire       reset_n,       // sync reset, active low
   input  wire       bus_backoff,   // release request
   input  wire [3:0] rel_delay,     // clocks to finish current transfer
   output reg        div32_en,      // one clock in 32
   output reg        bus_released   // controller let go
);
   reg [4:0] div_reg;
   reg [3:0] wait_reg;
   // master cell refreshes its code, enable pulse once per 32 clocks
   always @(posedge clk) begin
      div_reg  <= reset_n ? div_reg + 5'h01 : 5'h00;
      div32_en <= reset_n && div_reg == 5'h1f;
   end
   // controller ends its transfer before letting go, never earlier
   always @(posedge clk) begin
      if (!reset_n || !bus_backoff) begin
         wait_reg     <= 4'h0;
         bus_released <= 1'b0;
      end else if (wait_reg >= rel_delay) bus_released <= 1'b1;
      else wait_reg <= wait_reg + 4'h1;
   end
endmodule // dlo_mc_model

// ---- verif/dlo_offset_ctrl_tb.sv ----
/* testbench: apb register access, lane clamping and periodic updates.
 assumes dlo_offset_ctrl with the controller model on its bus side. */
`timescale 1ns/1ns
`include "dlo_defines.vh"
module dlo_offset_ctrl_tb;
   reg         CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, SYS_RELOAD_LOAD = 0, er;
   reg  [11:0] PADDR = 0;
   reg  [31:0] PWDATA = 0, rd, cfg, e;
   reg  [6:0]  RAW_CODE = 7'h40;
   reg  [7:0]  SYS_RELOAD = 8'h02;
   reg  [3:0]  rel_delay = 4'h3;
   wire [31:0] PRDATA;
   wire [27:0] LANE_CODES;
   wire        PREADY, PSLVERR, DIV32_EN, BUS_RELEASED, SLAVE_DELAY_LOAD_N, BUS_BACKOFF, BUS_GRANT, UPDATE_REQ;
   integer     err_count = 0, n_checks = 0, n, i;
   always #4 CLK = ~CLK;
   dlo_offset_ctrl dlo_offset_ctrl_inst (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .RAW_CODE(RAW_CODE), .DIV32_EN(DIV32_EN),
      .SYS_RELOAD(SYS_RELOAD), .SYS_RELOAD_LOAD(SYS_RELOAD_LOAD), .BUS_RELEASED(BUS_RELEASED),
      .LANE_CODES(LANE_CODES), .SLAVE_DELAY_LOAD_N(SLAVE_DELAY_LOAD_N),
      .BUS_BACKOFF(BUS_BACKOFF), .BUS_GRANT(BUS_GRANT), .UPDATE_REQ(UPDATE_REQ));
   dlo_mc_model dlo_mc_model_inst (.clk(CLK), .reset_n(RESET_N), .bus_backoff(BUS_BACKOFF),
      .rel_delay(rel_delay), .div32_en(DIV32_EN), .bus_released(BUS_RELEASED));
   // one lane: flag and clamped code, borrow or carry sets the flag
   function [7:0] lane(input [6:0] r, input [7:0] f);
      reg [7:0] s;
      begin
         s = f[7] ? {1'b0, r} - {1'b0, f[6:0]} : {1'b0, r} + {1'b0, f[6:0]};
         lane = s[7] ? {1'b1, f[7] ? 7'h00 : 7'h7f} : {1'b0, s[6:0]};
      end
   endfunction
   function [31:0] rb(input [6:0] r, input [31:0] c);
      rb = {lane(r, c[31:24]), lane(r, c[23:16]), lane(r, c[15:8]), lane(r, c[7:0])};
   endfunction
   task summarize;
      begin
         if (err_count == 0 && n_checks > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] ex);
      begin
         n_checks = n_checks + 1;
         if (got !== ex) begin
            err_count = err_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, ex);
         end
      end
   endtask
   // one apb transfer; request held until ready is sampled high
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge CLK);
         PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
         @(posedge CLK);
         PENABLE <= 1;
         n = 0;
         do begin @(posedge CLK); n = n + 1; end while (PREADY !== 1'b1 && n < 20);
         if (n >= 20) begin err_count = err_count + 1; summarize; end
         rd = PRDATA; er = PSLVERR; PSEL <= 0; PENABLE <= 0;
      end
   endtask
   // counts clocks up to the next slave load pulse
   task wait_load(input integer lim);
      begin
         n = 0;
         do begin @(posedge CLK); n = n + 1; end while (SLAVE_DELAY_LOAD_N !== 1'b0 && n < lim);
         if (n >= lim) begin err_count = err_count + 1; summarize; end
      end
   endtask
   initial begin
      repeat (5) @(posedge CLK);
      RESET_N <= 1;
      apb(0, `DLO_ADDR_CONFIG, 0); chk(rd, 0);
      apb(0, `DLO_ADDR_RELOAD, 0); chk(rd, 32'h36);
      apb(0, `DLO_ADDR_READBACK, 0); chk(rd, rb(7'h40, 0));
      chk({4'h0, LANE_CODES}, 0);
      cfg = 32'hd090_5010;
      apb(1, `DLO_ADDR_CONFIG, cfg); apb(0, `DLO_ADDR_CONFIG, 0); chk(rd, cfg);
      apb(1, `DLO_ADDR_READBACK, 32'hffff_ffff); apb(0, `DLO_ADDR_CONFIG, 0); chk(rd, cfg);
      // low clamp on the two subtracting lanes, high clamp on the two adding lanes, a plain case per lane
      for (i = 0; i < 3; i = i + 1) begin
         RAW_CODE <= (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'h40;
         apb(0, `DLO_ADDR_READBACK, 0); chk(rd, rb(RAW_CODE, cfg));
      end
      apb(0, 12'h010, 0); chk({rd[30:0], er}, 1);
      apb(1, `DLO_ADDR_RELOAD, 32'hffff_ff05); apb(0, `DLO_ADDR_RELOAD, 0); chk(rd, 5);
      SYS_RELOAD_LOAD <= 1;
      @(posedge CLK);
      SYS_RELOAD_LOAD <= 0;
      apb(0, `DLO_ADDR_RELOAD, 0); chk(rd, 2);
      // first update after the reset count, then reload periods
      wait_load(2000);
      e = rb(7'h40, cfg);
      chk({4'h0, LANE_CODES}, {4'h0, e[30:24], e[22:16], e[14:8], e[6:0]});
      wait_load(200); chk(n, 96);
      rel_delay <= 4'h0;
      wait_load(200); chk(n, 93);
      apb(0, `DLO_ADDR_UPDSTAT, 0); chk(rd, 32'h0000_0103);
      summarize;
   end
endmodule // dlo_offset_ctrl_tb
